/* File: hw/watchdog_regs.svh */
/*
 * Register offsets, field positions, reset values and counts of the
 * runaway-code watchdog. Assumes an 18-bit Avalon-MM byte address.
 */
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// ============================================================
// Register map
`define WDOG_SERVICE_IDX   18'h0ffff
`define WDOG_SERVICE_ADDR  (`WDOG_SERVICE_IDX << 2)
`define WDOG_STATUS_ADDR   18'h00000
`define WDOG_EVEN_ADDR     18'h00004
`define WDOG_ECLR_ADDR     18'h00008
`define WDOG_COUNT_ADDR    18'h0000c

// ============================================================
// Fields and widths
`define WDOG_PRE_W         12
`define WDOG_CNT_W         6
`define WDOG_SVC_LO        4
`define WDOG_EV_W          3
`define WDOG_EV_WDRST      0
`define WDOG_EV_SERVICE    1
`define WDOG_EV_STOP       2
`define WDOG_EV_RESET      3'h0

// ============================================================
// Counts, in crystal clock cycles
`define WDOG_TIMEOUT_LONG  18'h3fff0
`define WDOG_TIMEOUT_SHORT 18'h01ff0
`define WDOG_PULSE_TICKS   6'h20

`endif

/* File: hw/watchdog_pkg.sv */
/*
 * Types shared by the watchdog modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package watchdog_pkg;

  // Factory option bits as presented by the option register.
  typedef struct packed {
    logic short_timeout_select;
    logic watchdog_disable_option;
    logic stop_enable;
  } option_bits_t;

  // Debug conditions that can suppress the watchdog.
  typedef struct packed {
    logic monitor_mode;
    logic break_active;
  } debug_state_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOPPED,
    ST_RESETTING
  } wdog_state_t;

endpackage : watchdog_pkg

/* File: hw/reset_pulse_stretch.sv */
/*
 * Stretches a watchdog firing into a reset pin pulse of a fixed number
 * of crystal clock cycles. Assumes i_tick marks crystal rising edges.
 */
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_regs.svh"

module reset_pulse_stretch (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_start,
  input  wire logic i_tick,
  output var  logic o_active
);

  logic [5:0] left_q;
  logic [5:0] left_d;
  logic       active_d;

  // ============================================================
  // Pulse counter
  always_comb begin
    left_d   = left_q;
    active_d = o_active;
    if (i_start && !o_active) begin
      left_d   = `WDOG_PULSE_TICKS;
      active_d = 1'b1;
    end else if (o_active && i_tick) begin
      left_d = left_q - 6'h01;
      if (left_q == 6'h01) begin
        active_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      left_q   <= 6'h00;
      o_active <= 1'b0;
    end else begin
      left_q   <= left_d;
      o_active <= active_d;
    end
  end

  // ============================================================
  // Checks
  logic [6:0] ticks_q;
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_active) begin
      ticks_q <= 7'h00;
    end else if (i_tick) begin
      ticks_q <= ticks_q + 7'h01;
    end
  end

  property p_pulse_len;
    @(posedge i_clk) disable iff (i_reset)
    $fell(o_active) |-> $past(ticks_q) == 7'h1f && $past(i_tick);
  endproperty
  a_pulse_len: assert property (p_pulse_len) // R6
    else $error("reset pulse not 32 crystal cycles");

endmodule : reset_pulse_stretch
`default_nettype wire

/* File: hw/runaway_code_watchdog.sv */
/*
 * Runaway-code watchdog: prescaler, watchdog counter, reset pulse,
 * service location and event registers on an Avalon-MM slave.
 * Assumes the crystal clock and the irq and reset pin test voltage
 * indications arrive asynchronously; CPU strobes and option bits share i_clk.
 */
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_regs.svh"

// Summary of operation
// [R1] 6-bit counter clocked by 12-bit prescaler carry
// [R2] Counts advance only on crystal clock edges
// [R3] Overflow resets after 2^13-16 or 2^18-16 cycles
// [R4] Service write clears counter and prescaler 12..5
// [R5] Service location reads reset vector low byte
// [R6] Reset pin low 32 cycles, cause flag set
// [R7] Stop clears prescaler, halts counting until exit
// [R8] Internal reset clears prescaler and counter
// [R9] Reset vector fetch clears prescaler
// [R10] Disable option suppresses watchdog resets
// [R11] Monitor mode with test voltage disables watchdog
// [R12] Break with reset-pin test voltage disables watchdog
// [R13] Keeps counting during wait mode
// [R14] Never raises a CPU interrupt
// [R15] Stop honoured only when stop enable set
// [R16] Software services after reset and around stop
// [R17] Software services from main loop, except wait
// [R18] Service write decoded and applied within bus cycle
module runaway_code_watchdog (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset,
  input  wire logic [17:0]               i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output var  logic [31:0]               o_avs_readdata,
  output var  logic                      o_avs_waitrequest,
  input  wire logic                      i_crystal_clock,
  input  wire watchdog_pkg::option_bits_t i_options,
  input  wire watchdog_pkg::debug_state_t i_debug,
  input  wire logic                      i_irq_pin_test_voltage,
  input  wire logic                      i_reset_pin_test_voltage,
  input  wire logic                      i_internal_reset,
  input  wire logic                      i_vector_fetch,
  input  wire logic                      i_stop_exec,
  input  wire logic                      i_stop_exit,
  input  wire logic [7:0]                i_reset_vector_low,
  output var  logic                      o_reset_pin_out,
  output var  logic                      o_reset_pin_oe,
  output var  logic                      o_watchdog_cause,
  output var  logic                      o_event_irq
);

  localparam int PW = `WDOG_PRE_W;
  localparam int CW = `WDOG_CNT_W;
  localparam int EW = `WDOG_EV_W;

  function automatic logic [17:0] join_count(input logic [CW-1:0] c,
                                              input logic [PW-1:0] p);
    join_count = {c, p};
  endfunction : join_count

  function automatic logic hit_limit(input logic [17:0] n,
                                     input logic        short_sel);
    hit_limit = short_sel ? (n == `WDOG_TIMEOUT_SHORT)
                          : (n == `WDOG_TIMEOUT_LONG);
  endfunction : hit_limit

  // ============================================================
  // Pin synchronisers
  // Bit 0 crystal clock, bit 1 irq test voltage, bit 2 reset test
  // voltage. A level is accepted only when stages two and three agree.
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] level_q;
  logic [2:0] level_d;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      level_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : level_q[i];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      level_q <= 3'h0;
    end else begin
      sync1_q <= {i_reset_pin_test_voltage, i_irq_pin_test_voltage,
                  i_crystal_clock};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  logic xtal_tick;
  logic dbg_off;
  assign xtal_tick = level_d[0] && !level_q[0]; // R2
  assign dbg_off = (i_debug.monitor_mode && (level_q[1] || level_q[2])) // R11
                || (i_debug.break_active && level_q[2]); // R12

  // ============================================================
  // Bus slave handshake
  // One wait state per access keeps read data a registered output.
  logic        wait_q;
  logic        wait_d;
  logic        req;
  logic        acc;
  logic        svc_write;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  assign req = i_avs_read || i_avs_write;
  assign acc = req && !wait_q;
  assign svc_write = acc && i_avs_write
                  && (i_avs_address == `WDOG_SERVICE_ADDR); // R18

  always_comb begin
    wait_d = !(req && wait_q);
  end

  // ============================================================
  // Prescaler, watchdog counter and state
  logic [PW-1:0]            pre_q;
  logic [PW-1:0]            pre_d;
  logic [CW-1:0]            cnt_q;
  logic [CW-1:0]            cnt_d;
  watchdog_pkg::wdog_state_t state_q;
  watchdog_pkg::wdog_state_t state_d;
  logic                     fire;
  logic                     pulse_active;
  logic                     int_rst;

  assign int_rst = i_internal_reset || state_q == watchdog_pkg::ST_RESETTING;

  always_comb begin
    logic [PW:0] pre_inc;
    pre_inc = {1'b0, pre_q} + {{PW{1'b0}}, 1'b1};
    pre_d   = pre_q;
    cnt_d   = cnt_q;
    state_d = state_q;
    fire    = 1'b0;
    // Wait mode has no input here: counting never looks at it.
    if (state_q == watchdog_pkg::ST_RUN && xtal_tick && !dbg_off) begin // R13
      pre_d = pre_inc[PW-1:0];
      cnt_d = cnt_q + {{(CW-1){1'b0}}, pre_inc[PW]}; // R1
      if (hit_limit(join_count(cnt_d, pre_d),
                    i_options.short_timeout_select)) begin // R3
        fire = !i_options.watchdog_disable_option; // R10
      end
    end
    if (i_vector_fetch) begin
      pre_d = '0; // R9
    end
    if (svc_write) begin
      cnt_d                          = '0; // R4
      pre_d[PW-1:`WDOG_SVC_LO]       = '0; // R4
      fire                           = 1'b0;
    end
    case (state_q)
      watchdog_pkg::ST_RUN: begin
        if (fire) begin
          state_d = watchdog_pkg::ST_RESETTING; // R3
        end else if (i_stop_exec && i_options.stop_enable) begin // R15
          state_d = watchdog_pkg::ST_STOPPED; // R7
          pre_d   = '0; // R7
        end
      end
      watchdog_pkg::ST_STOPPED: begin
        if (i_stop_exit) begin
          state_d = watchdog_pkg::ST_RUN;
        end
      end
      watchdog_pkg::ST_RESETTING: begin
        if (!pulse_active) begin
          state_d = watchdog_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = watchdog_pkg::ST_RUN;
      end
    endcase
    // A watchdog disabled by debug clears its counts so that leaving debug starts
    // a full period rather than a part-spent one.
    if (int_rst || dbg_off) begin
      pre_d = '0; // R8
      cnt_d = '0; // R8
    end
    if (i_internal_reset && state_q == watchdog_pkg::ST_STOPPED) begin
      state_d = watchdog_pkg::ST_RUN;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pre_q   <= '0;
      cnt_q   <= '0;
      state_q <= watchdog_pkg::ST_RUN;
    end else begin
      pre_q   <= pre_d;
      cnt_q   <= cnt_d;
      state_q <= state_d;
    end
  end

  reset_pulse_stretch u_pulse (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_start  (fire),
    .i_tick   (xtal_tick),
    .o_active (pulse_active)
  );

  // ============================================================
  // Events and registers
  // The event output goes to a system monitor, not the CPU, so the
  // watchdog itself still ends only in a reset.
  logic [EW-1:0] ev_q;
  logic [EW-1:0] ev_d;
  logic [EW-1:0] en_q;
  logic [EW-1:0] en_d;
  logic [EW-1:0] ev_set;
  logic          irq_d;
  logic          pin_oe_d;
  logic          stop_taken;

  assign stop_taken = state_q == watchdog_pkg::ST_RUN
                   && state_d == watchdog_pkg::ST_STOPPED;

  always_comb begin
    ev_set = '0;
    ev_set[`WDOG_EV_WDRST]   = fire; // R6
    ev_set[`WDOG_EV_SERVICE] = svc_write;
    ev_set[`WDOG_EV_STOP]    = stop_taken;
    ev_d = ev_q;
    en_d = en_q;
    if (acc && i_avs_write && i_avs_byteenable[0]) begin
      if (i_avs_address == `WDOG_ECLR_ADDR) begin
        ev_d = ev_q & ~i_avs_writedata[EW-1:0];
      end
      if (i_avs_address == `WDOG_EVEN_ADDR) begin
        en_d = i_avs_writedata[EW-1:0];
      end
    end
    ev_d     = ev_d | ev_set;
    irq_d    = |(ev_d & en_d); // R14
    pin_oe_d = fire || (pulse_active && state_d != watchdog_pkg::ST_RUN);
    rdata_d  = rdata_q;
    if (req && wait_q) begin
      rdata_d = 32'h0000_0000;
      case (i_avs_address)
        `WDOG_SERVICE_ADDR: rdata_d[7:0]    = i_reset_vector_low; // R5
        `WDOG_STATUS_ADDR:  rdata_d[EW-1:0] = ev_q;
        `WDOG_EVEN_ADDR:    rdata_d[EW-1:0] = en_q;
        `WDOG_COUNT_ADDR:   rdata_d[17:0]   = join_count(cnt_q, pre_q);
        default:            rdata_d         = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ev_q              <= `WDOG_EV_RESET;
      en_q              <= `WDOG_EV_RESET;
      o_event_irq       <= 1'b0;
      o_watchdog_cause  <= 1'b0;
      o_reset_pin_oe    <= 1'b0;
      o_reset_pin_out   <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
      wait_q            <= 1'b1;
    end else begin
      ev_q              <= ev_d;
      en_q              <= en_d;
      o_event_irq       <= irq_d;
      o_watchdog_cause  <= ev_d[`WDOG_EV_WDRST]; // R6
      o_reset_pin_oe    <= pin_oe_d; // R6
      o_reset_pin_out   <= 1'b0;
      o_avs_waitrequest <= wait_d;
      o_avs_readdata    <= rdata_d;
      wait_q            <= wait_d;
    end
  end

  assign rdata_q = o_avs_readdata;

  // ============================================================
  // Checks
  logic [17:0] cnt_all;
  logic        quiet;
  assign cnt_all = join_count(cnt_q, pre_q);
  assign quiet = !int_rst && !dbg_off && !svc_write && !i_vector_fetch;

  property p_carry;
    @(posedge i_clk) disable iff (i_reset)
    state_q == watchdog_pkg::ST_RUN && xtal_tick && &pre_q && quiet
      && !i_stop_exec
    |=> cnt_q == $past(cnt_q) + 6'h01 && pre_q == 12'h000;
  endproperty
  a_carry: assert property (p_carry) // R1
    else $error("prescaler carry did not advance counter");

  property p_xtal_only;
    @(posedge i_clk) disable iff (i_reset)
    !xtal_tick && quiet && !i_stop_exec |=> $stable(cnt_all);
  endproperty
  a_xtal_only: assert property (p_xtal_only) // R2
    else $error("count moved without a crystal edge");

  property p_timeout;
    @(posedge i_clk) disable iff (i_reset)
    state_q == watchdog_pkg::ST_RUN && xtal_tick && quiet
      && i_options.short_timeout_select
      && !i_options.watchdog_disable_option
      && cnt_all == `WDOG_TIMEOUT_SHORT - 18'h1
    |=> state_q == watchdog_pkg::ST_RESETTING && o_reset_pin_oe;
  endproperty
  a_timeout: assert property (p_timeout) // R3
    else $error("short timeout did not fire");

  property p_service;
    @(posedge i_clk) disable iff (i_reset)
    svc_write && !i_vector_fetch |=> cnt_q == 6'h00 && pre_q[11:4] == 8'h00;
  endproperty
  a_service: assert property (p_service) // R4
    else $error("service write did not clear counts");

  property p_vector_read;
    @(posedge i_clk) disable iff (i_reset)
    acc && i_avs_read && i_avs_address == `WDOG_SERVICE_ADDR
    |-> o_avs_readdata == {24'h0, $past(i_reset_vector_low)};
  endproperty
  a_vector_read: assert property (p_vector_read) // R5
    else $error("service read did not return vector byte");

  property p_int_reset;
    @(posedge i_clk) disable iff (i_reset)
    i_internal_reset |=> cnt_all == 18'h0;
  endproperty
  a_int_reset: assert property (p_int_reset) // R8
    else $error("internal reset left counts");

  property p_disable_opt;
    @(posedge i_clk) disable iff (i_reset)
    i_options.watchdog_disable_option
      && state_q == watchdog_pkg::ST_RUN
    |=> state_q != watchdog_pkg::ST_RESETTING;
  endproperty
  a_disable_opt: assert property (p_disable_opt) // R10
    else $error("reset issued while disabled");

  property p_debug_off;
    @(posedge i_clk) disable iff (i_reset)
    dbg_off |=> cnt_all == 18'h0 ##1 !$rose(o_reset_pin_oe);
  endproperty
  a_debug_off: assert property (p_debug_off) // R11
    else $error("watchdog ran under test voltage");

  property p_stop_inhibit;
    @(posedge i_clk) disable iff (i_reset)
    state_q == watchdog_pkg::ST_RUN && i_stop_exec
      && !i_options.stop_enable
    |=> state_q != watchdog_pkg::ST_STOPPED;
  endproperty
  a_stop_inhibit: assert property (p_stop_inhibit) // R15
    else $error("stop taken with stop disabled");

  property p_stopped;
    @(posedge i_clk) disable iff (i_reset)
    state_q == watchdog_pkg::ST_STOPPED && quiet |=> $stable(cnt_all);
  endproperty
  a_stopped: assert property (p_stopped) // R7
    else $error("counting while stopped");

endmodule : runaway_code_watchdog
`default_nettype wire

/* File: sim/crystal_pin_model.sv */
/*
 * Far-side model of the watchdog: a free-running crystal oscillator and
 * the open-drain reset pin with its pull-up. Assumes the bench clock
 * drives i_clk; the crystal runs at a quarter of that rate.
 */
`timescale 1ns/1ps
`default_nettype none

module crystal_pin_model (
  input  wire logic        i_clk,
  input  wire logic        i_pin_oe,
  input  wire logic        i_pin_out,
  output var  logic        o_crystal,
  output var  logic        o_pin_level,
  output var  logic [31:0] o_ticks
);
  // ============================================================
  // Oscillator
  // A real crystal never stops, so the model runs free; gating belongs
  // to the device.
  logic        phase_q = 1'b0;
  logic        xtal_q  = 1'b0;
  logic [31:0] ticks_q = 32'h0;

  always @(posedge i_clk) begin
    phase_q <= ~phase_q;
    if (phase_q) begin
      xtal_q <= ~xtal_q;
      if (!xtal_q) begin
        ticks_q <= ticks_q + 32'h1;
      end
    end
  end

  // ============================================================
  // Reset pin wire
  // The pull-up wins whenever nobody pulls the pin low.
  assign o_pin_level = i_pin_oe ? i_pin_out : 1'b1;
  assign o_crystal   = xtal_q;
  assign o_ticks     = ticks_q;
endmodule : crystal_pin_model

`default_nettype wire

/* File: sim/runaway_code_watchdog_tb_top.sv */
/*
 * Self-checking bench for the runaway-code watchdog: bus accesses,
 * timeout, reset pulse, service, options, debug and low-power inputs.
 * Assumes the crystal model ticks once every four bench clocks.
 */
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_regs.svh"

module runaway_code_watchdog_tb_top;
  // ============================================================
  // Signals
  logic        i_clk           = 1'b0;
  logic        i_reset         = 1'b1;
  logic [17:0] i_avs_address   = 18'h0;
  logic        i_avs_read      = 1'b0;
  logic        i_avs_write     = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  watchdog_pkg::option_bits_t i_options = '{1'b1, 1'b0, 1'b1};
  watchdog_pkg::debug_state_t i_debug   = '{1'b0, 1'b0};
  logic        irq_tv    = 1'b0;
  logic        rst_tv    = 1'b0;
  logic        int_rst   = 1'b0;
  logic        vec_fetch = 1'b0;
  logic        stop_exec = 1'b0;
  logic        stop_exit = 1'b0;
  logic [7:0]  vec_low   = 8'h00;
  logic        crystal;
  logic        pin_out;
  logic        pin_oe;
  logic        cause;
  logic        ev_irq;
  logic        pin_level;
  logic [31:0] ticks;
  logic [31:0] t0;
  logic [15:0] lfsr_q    = 16'h4505;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          err_total   = 0;
  int          checks_done = 0;
  int          oe_cycles   = 0;
  int          k;

  always #2.5 i_clk = ~i_clk;

  runaway_code_watchdog DUT (
    .i_clk(i_clk), .i_reset(i_reset),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_crystal_clock(crystal),
    .i_options(i_options), .i_debug(i_debug),
    .i_irq_pin_test_voltage(irq_tv), .i_reset_pin_test_voltage(rst_tv),
    .i_internal_reset(int_rst), .i_vector_fetch(vec_fetch),
    .i_stop_exec(stop_exec), .i_stop_exit(stop_exit),
    .i_reset_vector_low(vec_low), .o_reset_pin_out(pin_out),
    .o_reset_pin_oe(pin_oe), .o_watchdog_cause(cause),
    .o_event_irq(ev_irq)
  );

  crystal_pin_model far_side (
    .i_clk(i_clk), .i_pin_oe(pin_oe), .i_pin_out(pin_out),
    .o_crystal(crystal), .o_pin_level(pin_level), .o_ticks(ticks)
  );

  // ============================================================
  // Helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until waitrequest is sampled low, then releases it
  // and lets one edge pass so the next access never collides with it.
  task automatic bus(input logic wr, input logic [17:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_write     <= wr;
    i_avs_read      <= ~wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    if (n >= 50) begin
      err_total++;
      conclude();
    end
    @(posedge i_clk);
  endtask : bus

  task automatic rd(input logic [17:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic pulse(input int which);
    case (which)
      0: int_rst <= 1'b1;
      1: vec_fetch <= 1'b1;
      2: stop_exec <= 1'b1;
      default: stop_exit <= 1'b1;
    endcase
    @(posedge i_clk);
    {int_rst, vec_fetch, stop_exec, stop_exit} <= 4'h0;
    @(posedge i_clk);
  endtask : pulse

  task automatic wait_ticks(input int n);
    logic [31:0] s;
    int c;
    s = ticks;
    c = 0;
    while (int'(ticks - s) < n && c < 8 * n + 20) begin
      @(posedge i_clk);
      c++;
    end
    if (c >= 8 * n + 20) begin
      err_total++;
      conclude();
    end
  endtask : wait_ticks

  // ============================================================
  // Result monitor
  always @(posedge i_clk) begin
    if (pin_oe === 1'b1) oe_cycles++;
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(o_avs_readdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // ============================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    lfsr_q = lfsr_next(lfsr_q);
    vec_low <= lfsr_q[7:0];
    rd(`WDOG_SERVICE_ADDR, {24'h0, lfsr_q[7:0]}, 32'hffffffff);
    rd(`WDOG_STATUS_ADDR, 32'h0, 32'hffffffff);
    rd(`WDOG_EVEN_ADDR, 32'h0, 32'hffffffff);
    rd(`WDOG_ECLR_ADDR, 32'h0, 32'hffffffff);
    rd(18'h00010, 32'h0, 32'hffffffff);

    // Unserviced short timeout, then the pulse and its cause flag.
    pulse(0);
    t0 = ticks;
    k = 0;
    while (pin_oe !== 1'b1 && k < 40000) begin
      @(posedge i_clk);
      k++;
    end
    t0 = ticks - t0;
    check(32'(t0 >= 32'h1fed && t0 <= 32'h1ff3), 32'h1);
    check({31'h0, cause}, 32'h1);
    check({31'h0, pin_level}, 32'h0);
    t0 = ticks;
    k = 0;
    while (pin_oe === 1'b1 && k < 400) begin
      @(posedge i_clk);
      k++;
    end
    t0 = ticks - t0;
    check(32'(t0 >= 32'd31 && t0 <= 32'd33), 32'h1);
    rd(`WDOG_STATUS_ADDR, 32'h1, 32'h1);
    bus(1'b1, `WDOG_EVEN_ADDR, 32'h1);
    repeat (2) @(posedge i_clk);
    check({31'h0, ev_irq}, 32'h1);
    bus(1'b1, `WDOG_EVEN_ADDR, 32'h0);
    repeat (2) @(posedge i_clk);
    check({31'h0, ev_irq}, 32'h0);
    bus(1'b1, `WDOG_ECLR_ADDR, 32'h1);
    rd(`WDOG_STATUS_ADDR, 32'h0, 32'h1);

    // A service write part way through averts the reset.
    pulse(0);
    wait_ticks(2000);
    lfsr_q = lfsr_next(lfsr_q);
    bus(1'b1, `WDOG_SERVICE_ADDR, {16'h0, lfsr_q});
    rd(`WDOG_COUNT_ADDR, 32'h0, 32'h3ffe0);
    rd(`WDOG_STATUS_ADDR, 32'h2, 32'h2);
    k = oe_cycles;
    wait_ticks(6400);
    check(oe_cycles - k, 32'h0);

    // The disable option suppresses the reset past the short limit.
    i_options.watchdog_disable_option <= 1'b1;
    pulse(0);
    k = oe_cycles;
    wait_ticks(8300);
    check(oe_cycles - k, 32'h0);
    i_options.watchdog_disable_option <= 1'b0;

    // Test voltage in monitor or break state holds the counters.
    for (int i = 0; i < 3; i++) begin
      i_debug <= '{i < 2, i == 2};
      irq_tv  <= (i == 0);
      rst_tv  <= (i != 0);
      pulse(0);
      wait_ticks(40);
      rd(`WDOG_COUNT_ADDR, 32'h0, 32'h3ffff);
    end
    i_debug <= '{1'b0, 1'b0};
    {irq_tv, rst_tv} <= 2'h0;

    // A reset-vector fetch clears the prescaler.
    pulse(0);
    wait_ticks(100);
    pulse(1);
    rd(`WDOG_COUNT_ADDR, 32'h0, 32'hffc);

    // Stop halts counting when enabled and is ignored otherwise.
    pulse(2);
    rd(`WDOG_STATUS_ADDR, 32'h4, 32'h4);
    wait_ticks(60);
    rd(`WDOG_COUNT_ADDR, 32'h0, 32'hfff);
    pulse(3);
    i_options.stop_enable <= 1'b0;
    pulse(0);
    wait_ticks(100);
    pulse(2);
    wait_ticks(50);
    rd(`WDOG_COUNT_ADDR, 32'h80, 32'hf80);
    repeat (4) @(posedge i_clk);
    conclude();
  end
endmodule : runaway_code_watchdog_tb_top

`default_nettype wire
